// >>> hw/pmt_timer.sv
/*
 Period match timer with APB register access, sticky match flag,
 enable mask and a level interrupt output.
 Assumes a single 200 MHz clock, synchronous active-low reset and an
 APB master that holds each request until pready.
*/
// The address map and the APB register port were chosen for this implementation.
//
// Contract
// - Count increments from zero per prescaled instruction tick
// - Prescaler divides by 1, 4 or 16
// - Compare count with period every cycle
// - Match clears count next tick, clocks postscaler
// - Postscale ratio equals code plus one
// - Postscaler terminal count sets match flag
// - Interrupt only while match enable set
// - Reset clears count, period becomes all ones
// - Count or control write, reset clear scalers
// - Control write leaves count unchanged
// - Control bit 2 switches timer on
// - Count and period readable and writable anytime
// - Unscaled match pulse feeds capture/PWM units
// - Timer output offered as serial shift clock
`timescale 1ns/1ps
module pmt_timer #(
   parameter int COUNT_W = 8   // Timer count width
)(
   input  wire logic        ref_clk_i,         // 200 MHz system clock
   input  wire logic        rst_n_i,           // Sync reset, active low
   input  wire logic        psel_i,            // APB select
   input  wire logic        penable_i,         // APB access phase
   input  wire logic        pwrite_i,          // APB direction
   input  wire logic [7:0]  paddr_i,           // APB byte address
   input  wire logic [31:0] pwdata_i,          // APB write data
   output logic      [31:0] prdata_o,          // APB read data
   output logic             pready_o,          // APB ready
   output logic             pslverr_o,         // APB error
   output logic             irq_o,             // Level interrupt
   output logic             match_pulse_o,     // Unscaled match to capture/PWM
   output logic             shift_clk_o        // Timer output to serial port
);
   // Registers
   logic [COUNT_W-1:0] timer_count_reg;     // Timer count
   logic [COUNT_W-1:0] period_reg;          // Period value
   logic [6:0]         timer_control_reg;   // Control, bit 7 not stored
   logic               match_int_flag_reg;  // Sticky match flag
   logic               match_int_enable_reg; // Match interrupt enable
   logic [1:0]         div_cnt_reg;         // Instruction clock divider
   logic [3:0]         pre_cnt_reg;         // Prescale counter
   logic [3:0]         post_cnt_reg;        // Postscale counter
   logic               match_reg;           // Registered match pulse
   logic               toggle_reg;          // Shift clock toggle

   // Decoded strobes and ticks
   logic       wr_en;          // Write access phase
   logic       wr_count;       // Write to count
   logic       wr_control;     // Write to control
   logic       instr_tick;     // Instruction clock tick
   logic       pre_tick;       // Prescaled tick
   logic       timer_on;       // Timer running
   logic       match_now;      // Count equals period
   logic       post_terminal;  // Postscaler terminal count
   logic [3:0] pre_limit;      // Prescaler terminal value
   logic [1:0] prescale_select;
   logic [3:0] postscale_select;
   logic [31:0] read_word;     // Selected register, before capture
   logic [31:0] prdata_reg;    // Read data held for the access phase

   // Address decode shared by read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Single-cycle access: no wait states
   assign pready_o  = 1'b1;
   assign pslverr_o = 1'b0;
   assign wr_en     = psel_i && penable_i && pwrite_i;
   assign wr_count   = wr_en && hit(paddr_i, pmt_pkg::OFS_COUNT);
   assign wr_control = wr_en && hit(paddr_i, pmt_pkg::OFS_CONTROL);

   // Control fields
   assign timer_on         = timer_control_reg[pmt_pkg::CTL_ON_BIT];
   assign prescale_select  = timer_control_reg[pmt_pkg::CTL_PRE_LSB +: 2];
   assign postscale_select = timer_control_reg[pmt_pkg::CTL_POST_LSB +: 4];

   // Prescale terminal value; upper select bit wins
   always_comb
   begin
      if (prescale_select[1])
         pre_limit = pmt_pkg::PRE_LIM_DIV16;
      else if (prescale_select[0])
         pre_limit = pmt_pkg::PRE_LIM_DIV4;
      else
         pre_limit = pmt_pkg::PRE_LIM_DIV1;
   end

   // Instruction tick every fourth system clock
   assign instr_tick = (div_cnt_reg == 2'(pmt_pkg::INSTR_DIV - 1));
   // A tick that meets a count or control write is swallowed: that write
   // clears the prescaler, and the count must stay still on a control write
   assign pre_tick   = timer_on && instr_tick && (pre_cnt_reg == pre_limit)
                       && !wr_count && !wr_control;
   // Compare runs continuously; pulse only issued on a live tick
   assign match_now  = (timer_count_reg == period_reg);
   assign post_terminal = (post_cnt_reg == postscale_select);

   // Instruction clock divider, free running
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         div_cnt_reg <= 2'h0;
      else
         div_cnt_reg <= div_cnt_reg + 2'h1;
   end

   // Prescale counter
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i || wr_count || wr_control)
         pre_cnt_reg <= 4'h0;
      else if (timer_on && instr_tick)
         pre_cnt_reg <= (pre_cnt_reg == pre_limit) ? 4'h0 : pre_cnt_reg + 4'h1;
   end

   // Timer count; control writes do not touch it
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         timer_count_reg <= pmt_pkg::COUNT_RST;
      else if (wr_count)
         timer_count_reg <= pwdata_i[COUNT_W-1:0];
      else if (pre_tick && match_now)
         timer_count_reg <= '0;
      else if (pre_tick)
         timer_count_reg <= timer_count_reg + COUNT_W'(1);
   end

   // Period register
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         period_reg <= pmt_pkg::PERIOD_RST;
      else if (wr_en && hit(paddr_i, pmt_pkg::OFS_PERIOD))
         period_reg <= pwdata_i[COUNT_W-1:0];
   end

   // Control register, bit 7 not implemented
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         timer_control_reg <= pmt_pkg::CONTROL_RST;
      else if (wr_control)
         timer_control_reg <= pwdata_i[6:0];
   end

   // Match pulse, one system clock wide, the clock after the wrapping tick
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         match_reg <= 1'b0;
      else
         match_reg <= pre_tick && match_now;
   end

   // Postscale counter clocked by each match
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i || wr_count || wr_control)
         post_cnt_reg <= 4'h0;
      else if (pre_tick && match_now)
         post_cnt_reg <= post_terminal ? 4'h0 : post_cnt_reg + 4'h1;
   end

   // Shift clock: toggles on each match, giving half the match rate
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         toggle_reg <= 1'b0;
      else if (pre_tick && match_now)
         toggle_reg <= ~toggle_reg;
   end

   // Match flag: hardware set wins over a write-one clear
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         match_int_flag_reg <= 1'b0;
      else if (pre_tick && match_now && post_terminal)
         match_int_flag_reg <= 1'b1;
      else if (wr_en && hit(paddr_i, pmt_pkg::OFS_FLAG)
               && pwdata_i[pmt_pkg::FLAG_MATCH_BIT])
         match_int_flag_reg <= 1'b0;
   end

   // Interrupt enable mask
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         match_int_enable_reg <= 1'b0;
      else if (wr_en && hit(paddr_i, pmt_pkg::OFS_ENABLE))
         match_int_enable_reg <= pwdata_i[pmt_pkg::FLAG_MATCH_BIT];
   end

   // Outputs
   assign irq_o         = match_int_flag_reg && match_int_enable_reg;
   assign match_pulse_o = match_reg;
   assign shift_clk_o   = toggle_reg;

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      read_word = 32'h0000_0000;
      if (hit(paddr_i, pmt_pkg::OFS_COUNT))
         read_word[COUNT_W-1:0] = timer_count_reg;
      else if (hit(paddr_i, pmt_pkg::OFS_CONTROL))
         read_word[7:0] = {1'b0, timer_control_reg};
      else if (hit(paddr_i, pmt_pkg::OFS_PERIOD))
         read_word[COUNT_W-1:0] = period_reg;
      else if (hit(paddr_i, pmt_pkg::OFS_FLAG))
         read_word[pmt_pkg::FLAG_MATCH_BIT] = match_int_flag_reg;
      else if (hit(paddr_i, pmt_pkg::OFS_ENABLE))
         read_word[pmt_pkg::FLAG_MATCH_BIT] = match_int_enable_reg;
   end

   // Read data captured in the setup cycle, so the access phase sees a
   // flip-flop output and still needs no wait state
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         prdata_reg <= 32'h0000_0000;
      else if (psel_i && !penable_i)
         prdata_reg <= read_word;
   end

   assign prdata_o = prdata_reg;

   // Assertions
   property p_count_zero_after_match;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pre_tick && match_now && !wr_count) |=> (timer_count_reg == '0);
   endproperty
   a_count_zero_after_match: assert property (p_count_zero_after_match)
      else $error("count not cleared after match");

   property p_increment;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pre_tick && !match_now && !wr_count)
         |=> (timer_count_reg == $past(timer_count_reg) + COUNT_W'(1));
   endproperty
   a_increment: assert property (p_increment)
      else $error("count did not increment");

   property p_off_hold;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (!timer_on && !wr_count) |=> $stable(timer_count_reg);
   endproperty
   a_off_hold: assert property (p_off_hold)
      else $error("count moved while off");

   property p_ctl_write_keeps;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_control |=> (timer_count_reg == $past(timer_count_reg)
                      && pre_cnt_reg == 4'h0 && post_cnt_reg == 4'h0);
   endproperty
   a_ctl_write_keeps: assert property (p_ctl_write_keeps)
      else $error("control write disturbed count or scalers");

   property p_flag_set;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pre_tick && match_now && post_terminal) |=> match_int_flag_reg;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("match flag not set at terminal count");

   property p_irq_mask;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      irq_o |-> (match_int_enable_reg && match_int_flag_reg);
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt without enable");

   property p_pulse_one_cycle;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      match_pulse_o |=> !match_pulse_o;
   endproperty
   a_pulse_one_cycle: assert property (p_pulse_one_cycle)
      else $error("match pulse wider than one cycle");

   property p_prescale16;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pre_tick && prescale_select[1]) |-> ##1 ((!pre_tick || !prescale_select[1]) [*8]);
   endproperty
   a_prescale16: assert property (p_prescale16)
      else $error("prescale 16 ticked too soon");

   property p_bit7_zero;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (psel_i && penable_i && hit(paddr_i, pmt_pkg::OFS_CONTROL)) |-> (prdata_o[7] == 1'b0);
   endproperty
   a_bit7_zero: assert property (p_bit7_zero)
      else $error("control bit 7 not zero");

   // Scalers cleared by a count write; the count takes the written value
   property p_count_write_clears;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_count |=> (pre_cnt_reg == 4'h0 && post_cnt_reg == 4'h0
                    && timer_count_reg == $past(pwdata_i[COUNT_W-1:0]));
   endproperty
   a_count_write_clears: assert property (p_count_write_clears)
      else $error("count write did not clear scalers");

   property p_period_write;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_en && hit(paddr_i, pmt_pkg::OFS_PERIOD))
         |=> (period_reg == $past(pwdata_i[COUNT_W-1:0]));
   endproperty
   a_period_write: assert property (p_period_write)
      else $error("period write lost");

   property p_post_step;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pre_tick && match_now && !post_terminal)
         |=> (post_cnt_reg == $past(post_cnt_reg) + 4'h1);
   endproperty
   a_post_step: assert property (p_post_step)
      else $error("postscaler did not step on match");

   // Flag is sticky: only a written one clears it
   property p_flag_hold;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (match_int_flag_reg && !(wr_en && hit(paddr_i, pmt_pkg::OFS_FLAG)
                               && pwdata_i[pmt_pkg::FLAG_MATCH_BIT]))
         |=> match_int_flag_reg;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("match flag dropped without a clear");

   c_match: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) match_pulse_o);
   c_flag:  cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
                            $rose(match_int_flag_reg));
   c_irq:   cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(irq_o));
   c_pre16: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
                            pre_tick && prescale_select[1]);
endmodule

// >>> include/pmt_pkg.sv
/*
 Package for the period match timer: register offsets, field positions,
 reset values and timing constants.
 Assumes a 32-bit APB slave with one aligned word per register.
*/
package pmt_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_COUNT   = 8'h00;  // Timer count
   localparam logic [7:0] OFS_CONTROL = 8'h04;  // Timer control
   localparam logic [7:0] OFS_PERIOD  = 8'h08;  // Period value
   localparam logic [7:0] OFS_FLAG    = 8'h0C;  // Peripheral flag register 1
   localparam logic [7:0] OFS_ENABLE  = 8'h10;  // Peripheral enable register 1

   // Control field positions
   localparam int CTL_PRE_LSB  = 0;  // Prescale select, 2 bits
   localparam int CTL_ON_BIT   = 2;  // Timer on
   localparam int CTL_POST_LSB = 3;  // Postscale select, 4 bits
   localparam int FLAG_MATCH_BIT = 1;  // Match flag / enable position

   // Reset values
   localparam logic [7:0] COUNT_RST   = 8'h00;
   localparam logic [7:0] PERIOD_RST  = 8'hFF;
   localparam logic [6:0] CONTROL_RST = 7'h00;
   localparam logic [7:0] CONTROL_MASK = 8'h7F;  // Bit 7 reads zero

   // Prescale counter terminal values for divide by 1, 4 and 16
   localparam logic [3:0] PRE_LIM_DIV1  = 4'h0;
   localparam logic [3:0] PRE_LIM_DIV4  = 4'h3;
   localparam logic [3:0] PRE_LIM_DIV16 = 4'hF;

   // Instruction clock is system clock divided by this
   localparam int INSTR_DIV = 4;
endpackage

// >>> testbench/period_match_timer_tb.sv
/*
 Self-checking bench for the period match timer: APB register access,
 prescale and postscale timing, flag, mask and interrupt level.
 Assumes pmt_pkg is compiled first and a zero-wait APB slave.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module period_match_timer_tb;
   logic        ref_clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic        pready_o, pslverr_o, irq_o, match_pulse_o, shift_clk_o;
   int          failures, n_checks, n_match, n_tog, cyc, prev_cyc, gap;
   logic [31:0] mdl [5];     // Register mirror, index = address / 4
   logic [31:0] v;
   logic        sh_q;        // Previous shift clock level
   int          code, m0, t0, dv;

   pmt_timer DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
      .match_pulse_o(match_pulse_o), .shift_clk_o(shift_clk_o));

   // Clock, 5 ns period
   initial
   begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // Match pulse spacing and shift clock toggles
   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      sh_q <= shift_clk_o;
      if (rst_n_i && shift_clk_o !== sh_q) n_tog <= n_tog + 1;
      if (rst_n_i && match_pulse_o === 1'b1)
      begin
         n_match <= n_match + 1;
         gap <= cyc - prev_cyc;
         prev_cyc <= cyc;
      end
   end

   // Write, mirrored in the model; flag bits clear on one
   task apb_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel_i <= 1'b1; pwrite_i <= 1'b1; paddr_i <= a; pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do @(posedge ref_clk_i); while (pready_o !== 1'b1);
      psel_i <= 1'b0; penable_i <= 1'b0;
      if (a == pmt_pkg::OFS_FLAG) mdl[3] = mdl[3] & ~(d & 32'h0000_0002);
      else if (a == pmt_pkg::OFS_CONTROL) mdl[1] = d & 32'h0000_007F;
      else if (a < 8'h14) mdl[a >> 2] = d & 32'h0000_00FF & ((a == 8'h10) ? 2 : 'hFF);
   endtask

   // Read taken at the edge that samples pready
   task apb_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk_i);
      psel_i <= 1'b1; pwrite_i <= 1'b0; paddr_i <= a;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do @(posedge ref_clk_i); while (pready_o !== 1'b1);
      d = prdata_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
   endtask

   // Read one register and compare with the mirror
   task chk_reg(input logic [7:0] a);
      apb_rd(a, v);
      `CHK(v, (a < 8'h14) ? mdl[a >> 2] : 32'h0)
      `CHK(pslverr_o, 1'b0)
   endtask

   // Bounded wait for n more match pulses
   task wait_match(input int n);
      t0 = n_match;
      for (int i = 0; i < 3000 && n_match < t0 + n; i++) @(posedge ref_clk_i);
      if (n_match < t0 + n) failures++;   // Timed out
   endtask

   task tally_and_finish;
      if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog: bounded waits add up to about 27,000 cycles at worst
   initial
   begin
      #200000;
      failures++;
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(41802));
      {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {failures, n_checks, n_match, n_tog, cyc, prev_cyc, gap} = '0;
      sh_q = 1'b0;
      mdl = '{32'h0, 32'h0, 32'hFF, 32'h0, 32'h0};
      repeat (20) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      // Reset values, unmapped word included
      for (int i = 0; i < 6; i++) chk_reg(8'(i * 4));
      apb_wr(pmt_pkg::OFS_CONTROL, 32'hFFFF_FFFF);
      chk_reg(pmt_pkg::OFS_CONTROL);
      apb_wr(pmt_pkg::OFS_CONTROL, 32'h0);
      apb_wr(8'h14, 32'hFFFF_FFFF);   // Unmapped write ignored
      apb_wr(pmt_pkg::OFS_COUNT, 32'h33);
      apb_wr(pmt_pkg::OFS_CONTROL, 32'h02);
      chk_reg(pmt_pkg::OFS_COUNT);
      m0 = n_match;
      repeat (40) @(posedge ref_clk_i);
      chk_reg(pmt_pkg::OFS_COUNT);
      `CHK(n_match, m0)
      apb_wr(pmt_pkg::OFS_PERIOD, 32'($urandom_range(0, 255)));
      chk_reg(pmt_pkg::OFS_PERIOD);
      // Every prescale code, period 3: gap is 4 ticks of 4 clocks times divide
      for (int p = 0; p < 4; p++)
      begin
         dv = (p == 0) ? 1 : (p == 1) ? 4 : 16;
         apb_wr(pmt_pkg::OFS_PERIOD, 32'h3);
         apb_wr(pmt_pkg::OFS_COUNT, 32'h0);
         apb_wr(pmt_pkg::OFS_CONTROL, 32'(4 + p));
         wait_match(3);
         `CHK(gap, 16 * dv)
         m0 = n_tog - n_match;
         wait_match(1);
         repeat (4) @(posedge ref_clk_i);
         `CHK(n_tog - n_match, m0)
      end
      // Random postscale: flag after code+1 matches
      code = $urandom_range(0, 15);
      apb_wr(pmt_pkg::OFS_CONTROL, 32'h0);
      apb_wr(pmt_pkg::OFS_FLAG, 32'h2);
      apb_wr(pmt_pkg::OFS_ENABLE, 32'h2);
      apb_wr(pmt_pkg::OFS_PERIOD, 32'h1);
      apb_wr(pmt_pkg::OFS_COUNT, 32'h0);
      m0 = n_match;
      apb_wr(pmt_pkg::OFS_CONTROL, 32'((code << 3) + 4));
      for (int i = 0; i < 3000 && irq_o !== 1'b1; i++) @(posedge ref_clk_i);
      if (irq_o !== 1'b1) failures++;   // Timed out
      repeat (3) @(posedge ref_clk_i);
      `CHK(n_match - m0, code + 1)
      apb_wr(pmt_pkg::OFS_CONTROL, 32'h0);
      mdl[3] = 32'h2;
      chk_reg(pmt_pkg::OFS_FLAG);
      `CHK(irq_o, 1'b1)
      apb_wr(pmt_pkg::OFS_ENABLE, 32'h0);
      @(posedge ref_clk_i);
      `CHK(irq_o, 1'b0)
      apb_wr(pmt_pkg::OFS_ENABLE, 32'h2);
      apb_wr(pmt_pkg::OFS_FLAG, 32'h2);
      chk_reg(pmt_pkg::OFS_FLAG);
      `CHK(irq_o, 1'b0)
      // Reset in mid-run while counting: registers return to reset values
      apb_wr(pmt_pkg::OFS_PERIOD, 32'h80);
      apb_wr(pmt_pkg::OFS_CONTROL, 32'h04);
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      mdl = '{32'h0, 32'h0, 32'hFF, 32'h0, 32'h0};
      for (int i = 0; i < 5; i++) chk_reg(8'(i * 4));
      `CHK(irq_o, 1'b0)
      tally_and_finish();
   end
endmodule
